// File: verif/duc_counter_test.sv
// Self-checking bench for both variants of the up/down counter.
`timescale 1ns/1ps
module duc_counter_test;
    import duc_pkg::*;
    // ****************************************************************
    // Stimulus, model state and counters.
    // ****************************************************************
    logic        core_clk, nrst, clr, load_n, run;
    logic  [3:0] lv;
    wire logic   up, dn;
    duc_ctl_s    ctl, ctl_casc;
    wire logic [3:0] q [3];
    wire duc_flag_s  fl [3];
    logic [31:0] seed;
    int          cnt [3], fmx [3], fmn [3], pu [3], pd [3], n, mx, cu, cd, u2, d2;
    int          errors, num_checks, cyc;

    assign ctl      = '{up_clk: up, down_clk: dn, load_n: load_n, master_clear: clr};
    // The third counter hangs off the decimal one's flags with no glue logic.
    assign ctl_casc = '{up_clk: fl[0].max_flag_n, down_clk: fl[0].min_flag_n,
                        load_n: load_n, master_clear: clr};

    // Clock of 4 ns.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = !core_clk;
    end

    duc_drv drv (.core_clk(core_clk), .up_clk(up), .down_clk(dn));

    duc_counter #(.IS_BCD(1'b1)) dut (.core_clk(core_clk), .nrst(nrst), .ctl(ctl),
        .load_value_bit0(lv[0]), .load_value_bit1(lv[1]), .load_value_bit2(lv[2]),
        .load_value_bit3(lv[3]), .count_out_bit0(q[0][0]), .count_out_bit1(q[0][1]),
        .count_out_bit2(q[0][2]), .count_out_bit3(q[0][3]), .flags(fl[0]));
    duc_counter #(.IS_BCD(1'b0)) dut_bin (.core_clk(core_clk), .nrst(nrst), .ctl(ctl),
        .load_value_bit0(lv[0]), .load_value_bit1(lv[1]), .load_value_bit2(lv[2]),
        .load_value_bit3(lv[3]), .count_out_bit0(q[1][0]), .count_out_bit1(q[1][1]),
        .count_out_bit2(q[1][2]), .count_out_bit3(q[1][3]), .flags(fl[1]));
    duc_counter #(.IS_BCD(1'b1)) dut_casc (.core_clk(core_clk), .nrst(nrst), .ctl(ctl_casc),
        .load_value_bit0(lv[0]), .load_value_bit1(lv[1]), .load_value_bit2(lv[2]),
        .load_value_bit3(lv[3]), .count_out_bit0(q[2][0]), .count_out_bit1(q[2][1]),
        .count_out_bit2(q[2][2]), .count_out_bit3(q[2][3]), .flags(fl[2]));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk_count(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t flags got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Reference model, one edge at a time; 0 decimal, 1 binary, 2 cascaded decimal.
    always @(posedge core_clk) begin
        // The cascaded stage sees the flags that stage 0 showed before this edge.
        u2 = fmx[0];
        d2 = fmn[0];
        for (int i = 0; i < 3; i++) begin
            mx = (i == 1) ? 15 : 9;
            cu = (i == 2) ? u2 : up;
            cd = (i == 2) ? d2 : dn;
            if (!nrst) begin
                cnt[i] = 0;
                fmx[i] = 1;
                fmn[i] = 1;
            end else begin
                if (clr) n = 0;
                else if (!load_n) n = lv;
                else if (cu && !pu[i] && cd)
                    n = (cnt[i] >= mx) ? 0 : cnt[i] + 1;
                else if (cd && !pd[i] && cu)
                    n = (cnt[i] == 0) ? mx : cnt[i] - 1;
                else n = cnt[i];
                fmx[i] = !(n == mx && !cu);
                fmn[i] = !(n == 0 && !cd);
                cnt[i] = n;
            end
            pu[i] = nrst ? cu : 1;
            pd[i] = nrst ? cd : 1;
        end
    end

    // Outputs are settled by the falling edge.
    always @(negedge core_clk) begin
        if (run) begin
            for (int i = 0; i < 3; i++) begin
                chk_count(q[i], cnt[i][3:0]);
                chk_flags(fl[i], {fmx[i][0], fmn[i][0]});
            end
        end
    end

    // Hang guard.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            wrap_up();
        end
    end

    // Random mix of counts, refused edges, loads and clears.
    initial begin
        nrst = 1'b0;
        clr = 1'b0;
        load_n = 1'b1;
        lv = 4'h0;
        run = 1'b0;
        seed = 32'h0000_3669;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        run = 1'b1;
        for (int k = 0; k < 600; k++) begin
            @(negedge core_clk);
            seed = xs(seed);
            clr <= (seed[7:5] == 3'h0);
            load_n <= (seed[10:8] != 3'h0);
            lv <= seed[15:12];
            drv.pulse(seed[1:0]);
            // Now and then clear or load lands on the clock rise, which must be lost.
            clr <= (seed[18:16] == 3'h0);
            load_n <= (seed[21:19] != 3'h0);
        end
        @(negedge core_clk);
        clr <= 1'b0;
        load_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        wrap_up();
    end
endmodule

// File: verif/duc_drv.sv
// Model of the outside logic that drives the two count clocks.
`timescale 1ns/1ps
module duc_drv (
    // Bench clock.
    input  wire logic core_clk,
    // Count clocks towards the counter.
    output logic      up_clk,
    output logic      down_clk
);
    // Both clocks rest high so that neither direction is gated off.
    initial begin
        up_clk   = 1'b1;
        down_clk = 1'b1;
    end

    // One pulse: op 1 up, 2 down, 3 both low, the misuse the bench asks for.
    task automatic pulse(input logic [1:0] op);
        up_clk   <= !op[0];
        down_clk <= !op[1];
        @(negedge core_clk);
        up_clk   <= 1'b1;
        down_clk <= (op != 2'h3); // A held-low down clock blocks the up edge.
    endtask
endmodule

// File: verilog/duc_counter.sv
// Dual-clock presettable up/down counter, decimal or binary variant.
//
// Overview of operation
// - Four state flops, four load inputs, outputs.
// - Decimal or binary variant by parameter.
// - Master clear forces all count outputs low.
// - Low load control copies load inputs.
// - Up clock rise counts up, down high.
// - Down clock rise counts down, up high.
// - Both terminal flags rest high.
// - Max flag low at max, up low.
// - Min flag low at min, down low.
`timescale 1ns/1ps
module duc_counter
    import duc_pkg::*;
#(
    parameter logic IS_BCD = 1'b1
) (
    // Clock and system reset.
    input  wire logic      core_clk,
    input  wire logic      nrst,
    // Control lines and load value.
    input  wire duc_ctl_s  ctl,
    input  wire logic      load_value_bit0,
    input  wire logic      load_value_bit1,
    input  wire logic      load_value_bit2,
    input  wire logic      load_value_bit3,
    // Counter outputs.
    output logic           count_out_bit0,
    output logic           count_out_bit1,
    output logic           count_out_bit2,
    output logic           count_out_bit3,
    // Terminal flags for cascading.
    output duc_flag_s      flags
);

    // ****************************************************************
    // State and next values.
    // ****************************************************************
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic       up_prev_r;
    logic       down_prev_r;
    duc_flag_s  flags_r;
    duc_flag_s  flags_nxt;
    duc_act_e   act;
    logic [3:0] load_value;
    logic       up_rise;
    logic       down_rise;

    assign load_value = {load_value_bit3, load_value_bit2, load_value_bit1, load_value_bit0};
    assign up_rise    = ctl.up_clk & ~up_prev_r;
    assign down_rise  = ctl.down_clk & ~down_prev_r;

    // ****************************************************************
    // Action decode.
    // ****************************************************************

    // Both controls are taken at the core clock, so clear and load land one edge
    // later than on the discrete part; that is the price of registered outputs.
    always_comb begin
        if (ctl.master_clear) begin
            act = DUC_ACT_CLEAR;
        end else if (!ctl.load_n) begin
            act = DUC_ACT_LOAD;
        end else if (up_rise && ctl.down_clk) begin
            act = DUC_ACT_UP;
        end else if (down_rise && ctl.up_clk) begin
            act = DUC_ACT_DOWN;
        end else begin
            act = DUC_ACT_HOLD;
        end
    end

    // Wrap arithmetic of the chosen variant.
    duc_step #(
        .IS_BCD     (IS_BCD)
    ) u_step (
        .cur        (count_r),
        .act        (act),
        .load_value (load_value),
        .nxt        (count_nxt)
    );

    // A flag drops only while its own clock is low, so the next stage sees its
    // rising edge when this stage's clock returns high and the count wraps.
    always_comb begin
        flags_nxt.max_flag_n = ~((count_nxt == duc_max(IS_BCD)) && !ctl.up_clk);
        flags_nxt.min_flag_n = ~((count_nxt == DUC_MIN) && !ctl.down_clk);
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************

    // Four state flops and the clock edge history.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            count_r     <= DUC_CNT_RST;
            up_prev_r   <= DUC_CLK_RST;
            down_prev_r <= DUC_CLK_RST;
            flags_r     <= {DUC_FLAG_RST, DUC_FLAG_RST};
        end else begin
            count_r     <= count_nxt;
            up_prev_r   <= ctl.up_clk;
            down_prev_r <= ctl.down_clk;
            flags_r     <= flags_nxt;
        end
    end

    assign count_out_bit0 = count_r[0];
    assign count_out_bit1 = count_r[1];
    assign count_out_bit2 = count_r[2];
    assign count_out_bit3 = count_r[3];
    assign flags          = flags_r;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_up_req;
        ctl.load_n && !ctl.master_clear && up_rise && ctl.down_clk;
    endsequence

    sequence s_down_req;
        ctl.load_n && !ctl.master_clear && down_rise && ctl.up_clk;
    endsequence

    sequence s_quiet;
        ctl.load_n && !ctl.master_clear && !up_rise && !down_rise;
    endsequence

    chk_clear_zero: assert property (ctl.master_clear |=> count_r == DUC_MIN)
        else $error("Master clear did not zero the counter.");

    chk_load_copy: assert property (
        !ctl.load_n && !ctl.master_clear |=> count_r == $past(load_value))
        else $error("Load did not copy the load value.");

    chk_up_step: assert property (
        s_up_req |=> count_r == duc_inc($past(count_r), IS_BCD))
        else $error("Up edge did not count up.");

    chk_down_step: assert property (
        s_down_req |=> count_r == duc_dec($past(count_r), IS_BCD))
        else $error("Down edge did not count down.");

    chk_hold_stable: assert property (s_quiet |=> $stable(count_r))
        else $error("Counter moved without a request.");

    chk_max_flag: assert property (
        !ctl.up_clk |=> flags.max_flag_n == (count_r != duc_max(IS_BCD)))
        else $error("Max flag wrong while up clock low.");

    chk_min_flag: assert property (
        !ctl.down_clk |=> flags.min_flag_n == (count_r != DUC_MIN))
        else $error("Min flag wrong while down clock low.");

    chk_flags_rest: assert property (
        ctl.up_clk && ctl.down_clk |=> flags.max_flag_n && flags.min_flag_n)
        else $error("Flags not high with both clocks high.");

    chk_clear_priority: assert property (
        ctl.master_clear && !ctl.load_n |=> count_r == DUC_MIN)
        else $error("Load overrode master clear.");

    chk_wrap_up: assert property (
        s_up_req and (count_r == duc_max(IS_BCD)) |=> count_r == DUC_MIN)
        else $error("Up count did not wrap to zero.");

    chk_wrap_down: assert property (
        s_down_req and (count_r == DUC_MIN) |=> count_r == duc_max(IS_BCD))
        else $error("Down count did not wrap to the upper limit.");

    // ****************************************************************
    // Refused edges and priority.
    // ****************************************************************

    // A rise that the other clock does not permit must leave the count alone.
    chk_up_refused: assert property (
        ctl.load_n && !ctl.master_clear && up_rise && !ctl.down_clk |=> $stable(count_r))
        else $error("Up edge counted while down clock was low.");

    chk_down_refused: assert property (
        ctl.load_n && !ctl.master_clear && down_rise && !ctl.up_clk |=> $stable(count_r))
        else $error("Down edge counted while up clock was low.");

    // A clock rise that lands on a load or a clear is simply lost.
    chk_load_over_clk: assert property (
        !ctl.load_n && !ctl.master_clear && (up_rise || down_rise)
            |=> count_r == $past(load_value))
        else $error("Count edge overrode a load.");

    chk_clear_over_clk: assert property (
        ctl.master_clear && (up_rise || down_rise) |=> count_r == DUC_MIN)
        else $error("Count edge overrode master clear.");

    // ****************************************************************
    // Pin-level pulses and flag rest levels.
    // ****************************************************************

    // These watch the pins rather than the rise signals, so a broken edge
    // history flop shows up here even where the rise checks would agree.
    sequence s_up_pulse;
        !ctl.up_clk ##1 (ctl.up_clk && ctl.down_clk && ctl.load_n && !ctl.master_clear);
    endsequence

    sequence s_down_pulse;
        !ctl.down_clk ##1 (ctl.down_clk && ctl.up_clk && ctl.load_n && !ctl.master_clear);
    endsequence

    chk_up_pulse: assert property (
        s_up_pulse |=> count_r == duc_inc($past(count_r), IS_BCD))
        else $error("Up pulse on the pin did not count up.");

    chk_down_pulse: assert property (
        s_down_pulse |=> count_r == duc_dec($past(count_r), IS_BCD))
        else $error("Down pulse on the pin did not count down.");

    // A flag may only sit low while its own clock is low.
    chk_max_idle: assert property (
        ctl.up_clk |=> flags.max_flag_n)
        else $error("Max flag low while up clock high.");

    chk_min_idle: assert property (
        ctl.down_clk |=> flags.min_flag_n)
        else $error("Min flag low while down clock high.");

endmodule

// File: verilog/duc_pkg.sv
// Package with the constants, types and step functions of the up/down counter.
package duc_pkg;

    // ****************************************************************
    // Widths, values after reset and count limits.
    // ****************************************************************
    localparam int           DUC_CNT_W    = 4;
    localparam logic [3:0]   DUC_CNT_RST  = 4'h0;
    localparam logic [3:0]   DUC_MIN      = 4'h0;
    localparam logic [3:0]   DUC_BCD_MAX  = 4'h9;
    localparam logic [3:0]   DUC_BIN_MAX  = 4'hF;
    localparam logic         DUC_FLAG_RST = 1'b1;
    localparam logic         DUC_CLK_RST  = 1'b1;

    // ****************************************************************
    // Action chosen for the counter in one cycle.
    // ****************************************************************
    typedef enum logic [2:0] {
        DUC_ACT_HOLD  = 3'b000,
        DUC_ACT_UP    = 3'b001,
        DUC_ACT_DOWN  = 3'b010,
        DUC_ACT_LOAD  = 3'b011,
        DUC_ACT_CLEAR = 3'b100
    } duc_act_e;

    // Control lines driven by the preceding stage or outside logic.
    typedef struct packed {
        logic up_clk;
        logic down_clk;
        logic load_n;
        logic master_clear;
    } duc_ctl_s;

    // Terminal flags, both active low.
    typedef struct packed {
        logic max_flag_n;
        logic min_flag_n;
    } duc_flag_s;

    // Upper count limit of the chosen variant.
    function automatic logic [3:0] duc_max(input logic is_bcd);
        return is_bcd ? DUC_BCD_MAX : DUC_BIN_MAX;
    endfunction

    // Count one up, wrapping at the upper limit.
    function automatic logic [3:0] duc_inc(input logic [3:0] v, input logic is_bcd);
        return (v >= duc_max(is_bcd)) ? DUC_MIN : 4'(v + 4'h1);
    endfunction

    // Count one down, wrapping at zero.
    function automatic logic [3:0] duc_dec(input logic [3:0] v, input logic is_bcd);
        return (v == DUC_MIN) ? duc_max(is_bcd) : 4'(v - 4'h1);
    endfunction

endpackage

// File: verilog/duc_step.sv
// Next-value calculator for the counter state.
`timescale 1ns/1ps
module duc_step
    import duc_pkg::*;
#(
    parameter logic IS_BCD = 1'b1
) (
    // Present state and chosen action.
    input  wire logic [3:0] cur,
    input  wire duc_act_e   act,
    input  wire logic [3:0] load_value,
    // Next state.
    output logic      [3:0] nxt
);

    // One case over the action keeps the priority decode in the caller.
    always_comb begin
        case (act)
            DUC_ACT_CLEAR: nxt = DUC_CNT_RST;
            DUC_ACT_LOAD:  nxt = load_value;
            DUC_ACT_UP:    nxt = duc_inc(cur, IS_BCD);
            DUC_ACT_DOWN:  nxt = duc_dec(cur, IS_BCD);
            default:       nxt = cur;
        endcase
    end

endmodule
